// ### pkg/rsw_pkg.sv
// constants for the reset cause, debug force reset and options block
package rsw_pkg;
  // register indices on the cpu and debug command ports
  localparam logic [1:0] ADDR_FLAGS = 2'h0;
  localparam logic [1:0] ADDR_DBG = 2'h1;
  localparam logic [1:0] ADDR_OPT1 = 2'h2;
  // cause flag positions and the debug force bit
  localparam int FLAG_PWR = 7;
  localparam int FLAG_PIN = 6;
  localparam int FLAG_WDOG = 5;
  localparam int FLAG_BADOP = 4;
  localparam int FLAG_BADADDR = 3;
  localparam int FLAG_REFLOST = 2;
  localparam int FLAG_LOWSUP = 1;
  localparam int DBG_FORCE_BIT = 0;
  // options register fields
  localparam int OPT_TO_HI = 7;
  localparam int OPT_TO_LO = 6;
  localparam int OPT_STOP = 5;
  localparam int OPT_SER2 = 4;
  localparam int OPT_TWI = 3;
  // reset and read values
  localparam logic [7:0] FLAGS_POR = 8'h82;
  localparam logic [7:0] OPT1_RESET = 8'hC0;
  localparam logic [7:0] OPT1_MASK = 8'hF8;
  localparam logic [7:0] DBG_READ = 8'h00;
  // watchdog restart keys
  localparam logic [7:0] KEY1 = 8'h55;
  localparam logic [7:0] KEY2 = 8'hAA;
  // watchdog counts, slow tick source
  localparam int WD_LPO_CNT1 = 32;
  localparam int WD_LPO_CNT2 = 256;
  localparam int WD_LPO_CNT3 = 1024;
  // watchdog counts and window openings, bus clock source
  localparam int WD_BUS_CNT1 = 8192;
  localparam int WD_BUS_CNT2 = 65536;
  localparam int WD_BUS_CNT3 = 262144;
  localparam int WD_WIN1 = 6144;
  localparam int WD_WIN2 = 49152;
  localparam int WD_WIN3 = 196608;
  localparam int WD_CW = 18;
  // cycles the system reset output is held
  localparam int RESET_HOLD_CYC = 4;
  localparam logic [2:0] HOLD_LAST = 3'(RESET_HOLD_CYC - 1);
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_HOLD = 2'b10
  } rsw_state_t;
endpackage

// ### core/rsw_wdog.sv
// watchdog counter with selectable source, length and restart window
module rsw_wdog #(
  parameter int BUS_CNT1 = rsw_pkg::WD_BUS_CNT1,
  parameter int BUS_CNT2 = rsw_pkg::WD_BUS_CNT2,
  parameter int BUS_CNT3 = rsw_pkg::WD_BUS_CNT3,
  parameter int WIN1 = rsw_pkg::WD_WIN1,
  parameter int WIN2 = rsw_pkg::WD_WIN2,
  parameter int WIN3 = rsw_pkg::WD_WIN3
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // control
  input wire logic clear,
  input wire logic lpo_tick,
  input wire logic [1:0] timeout_sel,
  input wire logic clk_sel,
  input wire logic window_en,
  // status
  output logic expired_q,
  output logic window_open
);
  localparam int CW = rsw_pkg::WD_CW;
  logic [CW-1:0] count_q;
  logic [CW-1:0] last_w;
  logic [CW-1:0] win_w;
  logic tick_w;
  logic on_w;

  // last count before expiry for each code and source
  function automatic logic [CW-1:0] last_of(input logic [1:0] sel, input logic bus);
    logic [CW-1:0] r;
    r = '0;
    if (bus)
    begin
      if (sel == 2'h1) r = CW'(BUS_CNT1 - 1);
      else if (sel == 2'h2) r = CW'(BUS_CNT2 - 1);
      else if (sel == 2'h3) r = CW'(BUS_CNT3 - 1);
    end
    else
    begin
      if (sel == 2'h1) r = CW'(rsw_pkg::WD_LPO_CNT1 - 1);
      else if (sel == 2'h2) r = CW'(rsw_pkg::WD_LPO_CNT2 - 1);
      else if (sel == 2'h3) r = CW'(rsw_pkg::WD_LPO_CNT3 - 1);
    end
    return r;
  endfunction

  assign last_w = last_of(timeout_sel, clk_sel);
  assign on_w = timeout_sel != 2'h0;
  assign tick_w = clk_sel | lpo_tick;
  assign win_w = (timeout_sel == 2'h1) ? CW'(WIN1) :
                 (timeout_sel == 2'h2) ? CW'(WIN2) : CW'(WIN3);
  assign window_open = !(window_en && clk_sel) || (count_q >= win_w);

  // counter; expiry is a one-cycle pulse
  always_ff @(posedge sys_clk)
  begin
    if (rst || clear)
    begin
      count_q <= '0;
      expired_q <= 1'b0;
    end
    else if (on_w && tick_w)
    begin
      expired_q <= count_q == last_w;
      count_q <= (count_q == last_w) ? '0 : count_q + 1'b1;
    end
    else
    begin
      expired_q <= 1'b0;
    end
  end

  chk_wd_clear_zero: assert property (@(posedge sys_clk) disable iff (rst)
    clear |=> count_q == '0) else $error("watchdog count not zero after clear");
  chk_wd_tick_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !clear && !clk_sel && !lpo_tick |=> count_q == $past(count_q))
    else $error("watchdog counted without a slow tick");
  chk_wd_expire_at: assert property (@(posedge sys_clk) disable iff (rst)
    expired_q |-> $past(count_q) == $past(last_w) && count_q == '0)
    else $error("watchdog expired at the wrong count");
endmodule

// ### core/rsw_top.sv
// reset cause recorder, debug forced reset, options register and watchdog
module rsw_top #(
  parameter int BUS_CNT1 = rsw_pkg::WD_BUS_CNT1,
  parameter int BUS_CNT2 = rsw_pkg::WD_BUS_CNT2,
  parameter int BUS_CNT3 = rsw_pkg::WD_BUS_CNT3,
  parameter int WIN1 = rsw_pkg::WD_WIN1,
  parameter int WIN2 = rsw_pkg::WD_WIN2,
  parameter int WIN3 = rsw_pkg::WD_WIN3
) (
  // clock and power-on reset
  input wire logic sys_clk,
  input wire logic rst,
  // cpu register port
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [1:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata_q,
  // serial debug command port, writes only
  input wire logic dbg_wr,
  input wire logic [1:0] dbg_addr,
  input wire logic [7:0] dbg_wdata,
  // reset sources
  input wire logic ext_reset_n,
  input wire logic bad_opcode_evt,
  input wire logic bad_address_evt,
  input wire logic ref_lost_evt,
  input wire logic low_supply_evt,
  input wire logic low_supply_reset_en,
  // instruction events
  input wire logic stop_instr_evt,
  input wire logic background_entry_instr,
  input wire logic background_mode_en,
  // watchdog source and mode
  input wire logic lpo_tick,
  input wire logic watchdog_clk_sel,
  input wire logic watchdog_window_en,
  // system outputs
  output logic sys_reset_q,
  output logic stop_enter_q,
  output logic stop_allow_q,
  output logic serial2_route_sel_q,
  output logic twowire_route_sel_q,
  output logic watchdog_enable_q
);
  rsw_pkg::rsw_state_t state_q;
  logic [2:0] hold_q;
  logic [7:0] flags_q;
  logic [7:0] opt1_q;
  logic opt_written_q;
  logic armed_q;
  logic [7:0] cause_w;
  logic [7:0] rd_mux_w;
  logic in_run;
  logic wr_flags;
  logic wr_opt;
  logic wr_dbg_user;
  logic dbg_force;
  logic any_cause;
  logic wd_enabled;
  logic wd_expired;
  logic wd_window_open;
  logic key1_w;
  logic key2_w;
  logic wd_bad_val;
  logic wd_early;
  logic wd_restart;
  logic badop_w;

  // address match, shared by both ports
  function automatic logic hit(input logic [1:0] addr, input logic [1:0] target);
    return addr == target;
  endfunction

  // register strobes; writes during reset hold are dropped
  assign in_run = state_q == rsw_pkg::ST_RUN;
  assign wr_flags = in_run && cpu_wr && hit(cpu_addr, rsw_pkg::ADDR_FLAGS);
  assign wr_opt = in_run && cpu_wr && hit(cpu_addr, rsw_pkg::ADDR_OPT1);
  assign wr_dbg_user = cpu_wr && hit(cpu_addr, rsw_pkg::ADDR_DBG);
  assign dbg_force = in_run && dbg_wr && hit(dbg_addr, rsw_pkg::ADDR_DBG)
                     && dbg_wdata[rsw_pkg::DBG_FORCE_BIT];

  // watchdog service writes
  assign wd_enabled = opt1_q[rsw_pkg::OPT_TO_HI:rsw_pkg::OPT_TO_LO] != 2'h0;
  assign key1_w = cpu_wdata == rsw_pkg::KEY1;
  assign key2_w = cpu_wdata == rsw_pkg::KEY2;
  assign wd_bad_val = wd_enabled && wr_flags && !key1_w && !key2_w;
  assign wd_early = wd_enabled && wr_flags && !wd_window_open;
  assign wd_restart = wr_flags && key2_w && armed_q && !wd_early;

  assign badop_w = bad_opcode_evt
                   || (stop_instr_evt && !opt1_q[rsw_pkg::OPT_STOP])
                   || (background_entry_instr && !background_mode_en);

  // cause vector in flag layout, all active at the same entry are kept unless a debug force in that cycle records none
  assign cause_w[rsw_pkg::FLAG_PWR] = 1'b0;
  assign cause_w[rsw_pkg::FLAG_PIN] = !ext_reset_n;
  // timeout, bad value or early write
  assign cause_w[rsw_pkg::FLAG_WDOG] = wd_expired || wd_bad_val || wd_early;
  assign cause_w[rsw_pkg::FLAG_BADOP] = badop_w;
  assign cause_w[rsw_pkg::FLAG_BADADDR] = bad_address_evt;
  assign cause_w[rsw_pkg::FLAG_REFLOST] = ref_lost_evt;
  assign cause_w[rsw_pkg::FLAG_LOWSUP] = low_supply_evt && low_supply_reset_en;
  assign cause_w[0] = 1'b0;
  assign any_cause = in_run && ((cause_w != 8'h00) || dbg_force);

  // reset sequencer: records causes on entry, holds reset a few cycles
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      flags_q <= rsw_pkg::FLAGS_POR;
      state_q <= rsw_pkg::ST_HOLD;
      hold_q <= rsw_pkg::HOLD_LAST;
      sys_reset_q <= 1'b1;
    end
    else
    begin
      case (state_q)
        rsw_pkg::ST_RUN:
        begin
          if (any_cause)
          begin
            flags_q <= dbg_force ? 8'h00 : cause_w;
            state_q <= rsw_pkg::ST_HOLD;
            hold_q <= rsw_pkg::HOLD_LAST;
            sys_reset_q <= 1'b1;
          end
        end
        rsw_pkg::ST_HOLD:
        begin
          // a pin still held low stretches the reset
          if (hold_q != 3'h0)
          begin
            hold_q <= hold_q - 3'h1;
          end
          else if (ext_reset_n)
          begin
            state_q <= rsw_pkg::ST_RUN;
            sys_reset_q <= 1'b0;
          end
        end
        default:
        begin
          state_q <= rsw_pkg::ST_HOLD;
          hold_q <= rsw_pkg::HOLD_LAST;
          sys_reset_q <= 1'b1;
        end
      endcase
    end
  end

  // options register, write-once per reset so stray writes cannot retune it
  always_ff @(posedge sys_clk)
  begin
    if (rst || sys_reset_q)
    begin
      opt1_q <= rsw_pkg::OPT1_RESET;
      opt_written_q <= 1'b0;
    end
    else if (wr_opt && !opt_written_q)
    begin
      opt1_q <= cpu_wdata & rsw_pkg::OPT1_MASK;
      opt_written_q <= 1'b1;
    end
  end

  // first service key; any service write other than 55 disarms
  always_ff @(posedge sys_clk)
  begin
    if (rst || sys_reset_q)
    begin
      armed_q <= 1'b0;
    end
    else if (wr_flags)
    begin
      armed_q <= key1_w;
    end
  end

  rsw_wdog #(
    .BUS_CNT1(BUS_CNT1),
    .BUS_CNT2(BUS_CNT2),
    .BUS_CNT3(BUS_CNT3),
    .WIN1(WIN1),
    .WIN2(WIN2),
    .WIN3(WIN3)
  ) u_wdog (
    .sys_clk(sys_clk),
    .rst(rst),
    .clear(sys_reset_q || wd_restart),
    .lpo_tick(lpo_tick),
    .timeout_sel(opt1_q[rsw_pkg::OPT_TO_HI:rsw_pkg::OPT_TO_LO]),
    .clk_sel(watchdog_clk_sel),
    .window_en(watchdog_window_en),
    .expired_q(wd_expired),
    .window_open(wd_window_open)
  );

  // read selection
  // debug register reads zero
  assign rd_mux_w = hit(cpu_addr, rsw_pkg::ADDR_FLAGS) ? flags_q :
                    hit(cpu_addr, rsw_pkg::ADDR_OPT1) ? opt1_q : rsw_pkg::DBG_READ;

  // read data lands one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cpu_rdata_q <= 8'h00;
    end
    else
    begin
      cpu_rdata_q <= cpu_rd ? rd_mux_w : 8'h00;
    end
  end

  // stop entry pulse and registered option outputs
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      stop_enter_q <= 1'b0;
      stop_allow_q <= 1'b0;
      serial2_route_sel_q <= 1'b0;
      twowire_route_sel_q <= 1'b0;
      watchdog_enable_q <= 1'b0;
    end
    else
    begin
      stop_enter_q <= in_run && !any_cause && stop_instr_evt;
      stop_allow_q <= opt1_q[rsw_pkg::OPT_STOP];
      serial2_route_sel_q <= opt1_q[rsw_pkg::OPT_SER2];
      twowire_route_sel_q <= opt1_q[rsw_pkg::OPT_TWI];
      watchdog_enable_q <= wd_enabled;
    end
  end

  // checks against the cause recording, options register, debug register, stop trap and watchdog service and expiry
  chk_pwr_flags: assert property (@(posedge sys_clk)
    $fell(rst) |-> flags_q == 8'h82 && sys_reset_q)
    else $error("power-on flags wrong");
  chk_pin_flag: assert property (@(posedge sys_clk) disable iff (rst)
    in_run && !ext_reset_n && !dbg_force |=> sys_reset_q && flags_q[6])
    else $error("pin reset not recorded");
  chk_wdog_flag: assert property (@(posedge sys_clk) disable iff (rst)
    in_run && wd_expired && !dbg_force |=> sys_reset_q && flags_q[5])
    else $error("watchdog reset not recorded");
  chk_wdog_off: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(wd_enabled) |-> !wd_expired)
    else $error("watchdog expired while off");
  chk_badop_flag: assert property (@(posedge sys_clk) disable iff (rst)
    in_run && bad_opcode_evt && !dbg_force |=> sys_reset_q && flags_q[4])
    else $error("bad opcode not recorded");
  chk_background_entry_instr_illegal: assert property (@(posedge sys_clk) disable iff (rst)
    in_run && background_entry_instr && !background_mode_en && !dbg_force
    |=> flags_q[4]) else $error("background entry not illegal");
  chk_badaddr_flag: assert property (@(posedge sys_clk) disable iff (rst)
    in_run && bad_address_evt && !dbg_force |=> sys_reset_q && flags_q[3])
    else $error("bad address not recorded");
  chk_reflost_flag: assert property (@(posedge sys_clk) disable iff (rst)
    in_run && ref_lost_evt && !dbg_force |=> sys_reset_q && flags_q[2])
    else $error("clock loss not recorded");
  chk_lowsup_flag: assert property (@(posedge sys_clk) disable iff (rst)
    in_run && (low_supply_evt && low_supply_reset_en) != flags_q[1] && !dbg_force
    && (cause_w != 8'h00) |=> flags_q[1] == $past(low_supply_evt && low_supply_reset_en))
    else $error("low supply flag wrong");
  chk_user_dbg: assert property (@(posedge sys_clk) disable iff (rst)
    in_run && wr_dbg_user && !dbg_wr && cause_w == 8'h00 |=> !sys_reset_q)
    else $error("user write to debug register acted");
  chk_dbg_read: assert property (@(posedge sys_clk) disable iff (rst)
    cpu_rd && hit(cpu_addr, rsw_pkg::ADDR_DBG) |=> cpu_rdata_q == 8'h00)
    else $error("debug register read not zero");
  chk_dbg_force: assert property (@(posedge sys_clk) disable iff (rst)
    dbg_force |=> sys_reset_q && flags_q == 8'h00 ##1 sys_reset_q[*3])
    else $error("debug force reset wrong");
  chk_opt_once: assert property (@(posedge sys_clk) disable iff (rst)
    opt_written_q && !sys_reset_q |=> $stable(opt1_q) || $past(sys_reset_q))
    else $error("options changed after first write");
  chk_opt_low: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(sys_reset_q) |=> opt1_q == 8'hC0 && !opt_written_q)
    else $error("options reset value wrong");
  chk_stop_block: assert property (@(posedge sys_clk) disable iff (rst)
    in_run && stop_instr_evt && !opt1_q[5] && !dbg_force |=> !stop_enter_q && flags_q[4])
    else $error("disallowed stop not trapped");
  chk_key_bad: assert property (@(posedge sys_clk) disable iff (rst)
    in_run && wr_flags && wd_enabled && cpu_wdata != 8'h55 && cpu_wdata != 8'hAA
    && !dbg_force |=> sys_reset_q && flags_q[5])
    else $error("bad service value did not reset");
  chk_early_svc: assert property (@(posedge sys_clk) disable iff (rst)
    wd_enabled && wr_flags && !wd_window_open && !dbg_force |=> flags_q[5])
    else $error("early service did not reset");
endmodule

// ### test/rsw_host_model.sv
// debug host on the serial link and the slow tick source beside the block
module rsw_host_model #(
  parameter int TICK_DIV = 4
) (
  // clock
  input wire logic sys_clk,
  // command request from the bench
  input wire logic req,
  input wire logic [1:0] req_addr,
  input wire logic [7:0] req_data,
  // debug link and slow tick
  output logic dbg_wr,
  output logic [1:0] dbg_addr,
  output logic [7:0] dbg_wdata,
  output logic lpo_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  int div_q = 0;
  initial
  begin
    dbg_wr = 1'b0;
    dbg_addr = 2'h3;
    dbg_wdata = 8'hFF;
    lpo_tick = 1'b0;
  end
  always @(negedge sys_clk)
  begin
    if (dbg_wr)
    begin
      dbg_wr <= 1'b0;
      dbg_addr <= ~dbg_addr; // released lines must not keep the old value
      dbg_wdata <= ~dbg_wdata;
    end
    else if (req)
    begin
      dbg_wr <= 1'b1;
      dbg_addr <= req_addr;
      dbg_wdata <= req_data;
    end
  end
  // slow tick, one cycle wide, free running
  always @(negedge sys_clk)
  begin
    div_q <= (div_q == TICK_DIV - 1) ? 0 : div_q + 1;
    lpo_tick <= (div_q == TICK_DIV - 1);
  end
endmodule

// ### test/tb_reset_status_and_watchdog_options.sv
// self-checking bench for reset causes, debug reset, options and watchdog
module tb_reset_status_and_watchdog_options;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK_DIV = 4;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  logic [1:0] cpu_addr = 2'h0;
  logic [7:0] cpu_wdata = 8'h00;
  logic [7:0] cpu_rdata_q;
  logic req = 1'b0;
  logic [1:0] req_addr = 2'h0;
  logic [7:0] req_data = 8'h00;
  logic dbg_wr, lpo_tick;
  logic [1:0] dbg_addr;
  logic [7:0] dbg_wdata;
  logic [6:0] evt = 7'h00; // pin, opcode, address, clock, supply, stop, background
  logic lsr_en = 1'b0;
  logic bgm_en = 1'b0;
  logic clk_sel = 1'b1;
  logic win_en = 1'b0;
  logic sys_reset_q, stop_enter_q, stop_allow_q, ser_q, twi_q, wde_q;
  logic rst_prev = 1'b0;
  logic [7:0] d;
  int n_fail = 0;
  int n_compared = 0;
  int seed = 77259;
  int cyc = 0;
  int n_rst = 0;
  int n_stop = 0;
  int r0, n;
  int hi_len = 0;
  int last_hi = 0;

  // short bus counts keep the run brief; windows only tried on the shortest code
  rsw_top #(.BUS_CNT1(64), .BUS_CNT2(128), .BUS_CNT3(256), .WIN1(48))
  i_dut (.sys_clk(sys_clk), .rst(rst), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_rdata_q(cpu_rdata_q), .dbg_wr(dbg_wr), .dbg_addr(dbg_addr),
    .dbg_wdata(dbg_wdata), .ext_reset_n(~evt[0]), .bad_opcode_evt(evt[1]),
    .bad_address_evt(evt[2]), .ref_lost_evt(evt[3]), .low_supply_evt(evt[4]),
    .low_supply_reset_en(lsr_en), .stop_instr_evt(evt[5]), .background_entry_instr(evt[6]),
    .background_mode_en(bgm_en), .lpo_tick(lpo_tick), .watchdog_clk_sel(clk_sel),
    .watchdog_window_en(win_en), .sys_reset_q(sys_reset_q), .stop_enter_q(stop_enter_q),
    .stop_allow_q(stop_allow_q), .serial2_route_sel_q(ser_q), .twowire_route_sel_q(twi_q),
    .watchdog_enable_q(wde_q));
  rsw_host_model #(.TICK_DIV(TICK_DIV)) i_host (.sys_clk(sys_clk), .req(req),
    .req_addr(req_addr), .req_data(req_data), .dbg_wr(dbg_wr), .dbg_addr(dbg_addr),
    .dbg_wdata(dbg_wdata), .lpo_tick(lpo_tick));

  // clock, hang guard, reset and stop-entry monitors
  initial forever #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc++;
    if (sys_reset_q === 1'b1 && rst_prev === 1'b0) n_rst++;
    if (stop_enter_q === 1'b1) n_stop++;
    // length of the last reset pulse, counted in edges it was seen high
    if (sys_reset_q === 1'b1) hi_len++;
    else if (rst_prev === 1'b1)
    begin
      last_hi = hi_len;
      hi_len = 0;
    end
    rst_prev = sys_reset_q;
    if (cyc == 20000)
    begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    cpu_wr = 1'b1;
    cpu_addr = a;
    cpu_wdata = v;
    @(negedge sys_clk);
    cpu_wr = 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(negedge sys_clk);
    cpu_rd = 1'b1;
    cpu_addr = a;
    @(negedge sys_clk);
    cpu_rd = 1'b0;
    v = cpu_rdata_q;
  endtask
  task automatic dbg(input logic [1:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    req <= 1'b1;
    req_addr <= a;
    req_data <= v;
    @(negedge sys_clk);
    req <= 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic pulse(input int k);
    @(negedge sys_clk);
    evt[k] = 1'b1;
    @(negedge sys_clk);
    evt[k] = 1'b0;
  endtask
  task automatic service();
    wr(rsw_pkg::ADDR_FLAGS, rsw_pkg::KEY1);
    wr(rsw_pkg::ADDR_FLAGS, rsw_pkg::KEY2);
  endtask
  // wait for the reset, time its hold, read the cause, then set options once
  task automatic expect_reset(input logic [7:0] flags, input logic [7:0] opt);
    int m;
    logic [7:0] v;
    m = 0;
    while (sys_reset_q !== 1'b1 && m < 8)
    begin
      @(negedge sys_clk);
      m++;
    end
    check(sys_reset_q, 1'b1);
    m = 0;
    while (sys_reset_q === 1'b1 && m < 20)
    begin
      @(negedge sys_clk);
      m++;
    end
    check(sys_reset_q, 1'b0);
    rd(rsw_pkg::ADDR_FLAGS, v);
    check(v, flags);
    // pulse length from the monitor, whatever point this task was entered at
    check(last_hi, rsw_pkg::RESET_HOLD_CYC);
    // software writes options once after reset
    wr(rsw_pkg::ADDR_OPT1, opt);
  endtask
  task automatic measure(output int m);
    m = 0;
    while (sys_reset_q !== 1'b1 && m < 2000)
    begin
      @(negedge sys_clk);
      m++;
    end
  endtask

  // main sequence
  initial
  begin
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    repeat (8) @(negedge sys_clk);
    rd(rsw_pkg::ADDR_FLAGS, d);
    check(d, 8'h82);
    rd(rsw_pkg::ADDR_OPT1, d);
    check(d, 8'hC0);
    check(wde_q, 1'b1);
    // random options value, watchdog kept off; second write must not land
    d = 8'($random(seed));
    d[7:6] = 2'b00;
    wr(rsw_pkg::ADDR_OPT1, d);
    wr(rsw_pkg::ADDR_OPT1, ~d);
    rd(rsw_pkg::ADDR_OPT1, cpu_wdata);
    check(cpu_wdata, d & 8'hF8);
    check({stop_allow_q, ser_q, twi_q, wde_q}, {d[5], d[4], d[3], 1'b0});
    // cpu write to the debug register, bad key and silence with watchdog off
    r0 = n_rst;
    wr(rsw_pkg::ADDR_DBG, 8'h01);
    wr(rsw_pkg::ADDR_FLAGS, 8'h12);
    rd(rsw_pkg::ADDR_DBG, d);
    check(d, 8'h00);
    repeat (300) @(negedge sys_clk);
    dbg(rsw_pkg::ADDR_DBG, 8'hFE);
    dbg(rsw_pkg::ADDR_OPT1, 8'h01);
    pulse(4);
    check(n_rst, r0);
    dbg(rsw_pkg::ADDR_DBG, 8'h01);
    expect_reset(8'h00, 8'h00);
    lsr_en = 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      pulse(k);
      expect_reset(8'h40 >> (k == 0 ? 0 : k + 1), 8'h00);
    end
    pulse(5);
    expect_reset(8'h10, 8'h38);
    // option outputs follow the register one edge late
    @(negedge sys_clk);
    check({stop_allow_q, ser_q, twi_q}, 3'b111);
    r0 = n_rst;
    pulse(5);
    bgm_en = 1'b1;
    pulse(6);
    repeat (4) @(negedge sys_clk);
    check(n_stop, 1);
    check(n_rst, r0);
    bgm_en = 1'b0;
    pulse(6);
    expect_reset(8'h10, 8'h40);
    // expiry count of every timeout code on the bus clock
    for (int k = 1; k < 4; k++)
    begin
      service();
      measure(n);
      check(n >= (32 << k) - 2 && n <= (32 << k) + 3, 1'b1);
      expect_reset(8'h20, k < 3 ? 8'((k + 1) << 6) : 8'h40);
    end
    r0 = n_rst;
    repeat (4)
    begin
      repeat (20 + ($random(seed) & 15)) @(negedge sys_clk);
      service();
    end
    check(n_rst, r0);
    d = 8'($random(seed));
    if (d == rsw_pkg::KEY1 || d == rsw_pkg::KEY2) d = 8'h12;
    wr(rsw_pkg::ADDR_FLAGS, d);
    win_en = 1'b1;
    expect_reset(8'h20, 8'h40);
    service();
    expect_reset(8'h20, 8'h40);
    r0 = n_rst;
    repeat (2)
    begin
      repeat (47) @(negedge sys_clk);
      service();
    end
    check(n_rst, r0);
    win_en = 1'b0;
    clk_sel = 1'b0;
    service();
    measure(n);
    check(n >= 32 * TICK_DIV - 3 && n <= 32 * TICK_DIV + TICK_DIV + 3, 1'b1);
    expect_reset(8'h20, 8'h00);
    print_verdict();
  end
endmodule
